// ===== bench/fabric_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Memory side: program, data RAM, data flash, peripheral regs
// ==========================================================
module fabric_mem_model
(
    input wire logic clk,
    input wire logic [20:0] pmem_addr,
    input wire logic pmem_rd,
    input wire logic pmem_we,
    input wire logic [15:0] pmem_wdata,
    output logic [15:0] pmem_rdata,
    input wire logic [10:0] dram_addr,
    input wire logic dram_rd,
    input wire logic dram_we,
    input wire logic [3:0] dram_be,
    input wire logic [31:0] dram_wdata,
    output logic [31:0] dram_rdata,
    input wire logic [11:0] dram2_addr,
    input wire logic dram2_rd,
    output logic [15:0] dram2_rdata,
    input wire logic [11:0] dfl_addr,
    input wire logic dfl_rd,
    input wire logic dfl_we,
    input wire logic [1:0] dfl_be,
    input wire logic [15:0] dfl_wdata,
    output logic [15:0] dfl_rdata,
    input wire logic [11:0] pbus_addr,
    input wire logic pbus_rd,
    input wire logic pbus_we,
    input wire logic [1:0] pbus_be,
    input wire logic [15:0] pbus_wdata,
    output logic [15:0] pbus_rdata
);
    // Small arrays: only the low index bits are kept
    logic [15:0] pmem [256] = '{default: 16'h0000};
    logic [31:0] dram [256] = '{default: 32'h00000000};
    logic [15:0] dfl [256] = '{default: 16'h0000};
    logic [15:0] pbus [256] = '{default: 16'h0000};
    logic [31:0] dlong;

    // Stores land on the edge closing the cycle, per byte lane except program memory
    always @(posedge clk) begin
        if (pmem_we) begin
            pmem[pmem_addr[7:0]] <= pmem_wdata;
        end
        for (int i = 0; i < 4; i++) begin
            if (dram_we && dram_be[i]) begin
                dram[dram_addr[7:0]][8*i +: 8] <= dram_wdata[8*i +: 8];
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (dfl_we && dfl_be[i]) begin
                dfl[dfl_addr[7:0]][8*i +: 8] <= dfl_wdata[8*i +: 8];
            end
            if (pbus_we && pbus_be[i]) begin
                pbus[pbus_addr[7:0]][8*i +: 8] <= pbus_wdata[8*i +: 8];
            end
        end
    end

    // Unselected ports show inverted data so stale values never match
    assign dlong = dram[dram2_addr[8:1]];
    assign pmem_rdata = pmem_rd ? pmem[pmem_addr[7:0]] : ~pmem[pmem_addr[7:0]];
    assign dram_rdata = dram_rd ? dram[dram_addr[7:0]] : ~dram[dram_addr[7:0]];
    assign dram2_rdata = (dram2_addr[0] ? dlong[31:16] : dlong[15:0]) ^ {16{~dram2_rd}};
    assign dfl_rdata = dfl_rd ? dfl[dfl_addr[7:0]] : ~dfl[dfl_addr[7:0]];
    assign pbus_rdata = pbus_rd ? pbus[pbus_addr[7:0]] : ~pbus[pbus_addr[7:0]];
endmodule : fabric_mem_model

`default_nettype wire

// ===== bench/fabric_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Port checker of the bus fabric
// ==========================================================
module fabric_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [20:0] prog_addr,
    input wire logic prog_rd,
    input wire logic prog_wr,
    input wire logic [15:0] prog_rdata,
    input wire logic prog_rvalid,
    input wire logic [23:0] primary_data_address_bus,
    input wire logic pri_rd,
    input wire logic pri_wr,
    input wire fabric_pkg::size_t pri_size,
    input wire logic [31:0] core_wdata,
    input wire logic [31:0] core_rdata,
    input wire logic pri_rvalid,
    input wire logic [23:0] secondary_data_address_bus,
    input wire logic sec_rd,
    input wire logic sec_rvalid,
    input wire logic core_stall,
    input wire logic [20:0] pmem_addr,
    input wire logic pmem_rd,
    input wire logic pmem_we,
    input wire logic [15:0] pmem_wdata,
    input wire logic [15:0] pmem_rdata,
    input wire logic [10:0] dram_addr,
    input wire logic dram_rd,
    input wire logic dram_we,
    input wire logic [3:0] dram_be,
    input wire logic [31:0] dram_wdata,
    input wire logic [11:0] pbus_addr,
    input wire logic pbus_we,
    input wire logic [15:0] pbus_wdata,
    input wire logic [15:0] pbus_rdata
);
    import fabric_pkg::*;
    logic stall_r; // Second cycle of a collision
    wire logic [23:0] pa = primary_data_address_bus;
    // Byte cycles carry a byte address, so their word index sits one bit higher
    wire logic pri_dfl = (pri_size == SZ_BYTE) ? pa[22:13] == 10'h004 : pa[23:12] == 12'h004;
    wire logic sec_dfl = secondary_data_address_bus[23:12] == 12'h004;
    wire logic pri_pbus = pa[23:12] == 12'h00f;

    // Remember the stall so the held repeat cycle is excluded
    always_ff @(posedge clk) begin
        if (rst) begin
            stall_r <= 1'b0;
        end else begin
            stall_r <= core_stall;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_prog_fetch_word: assert property (prog_rd && !core_stall |=>
        prog_rvalid && prog_rdata == $past(pmem_rdata)) else $error("program read word lost");
    a_prog_addr_pass: assert property (prog_rd |-> pmem_rd && pmem_addr == prog_addr)
        else $error("program address not passed");
    a_prog_write_low: assert property (prog_wr && !core_stall && !stall_r |->
        pmem_we && pmem_wdata == core_wdata[15:0]) else $error("program write data wrong");
    a_long_ram_write: assert property (pri_wr && pri_size == SZ_LONG &&
        pa[23:12] == 12'h000 |-> dram_we && dram_be == BE_LONG && dram_wdata == core_wdata &&
        dram_addr == pa[11:1]) else $error("long write not passed whole");
    a_byte_msb_zero: assert property (pri_rd && pri_size == SZ_BYTE &&
        pa[22:13] == 10'h000 |-> dram_rd && dram_addr == pa[12:2])
        else $error("byte address top bit not cleared");
    a_pbus_write_data: assert property (pri_wr && pri_size == SZ_WORD && pri_pbus |->
        pbus_we && pbus_addr == pa[11:0] && pbus_wdata == core_wdata[15:0])
        else $error("peripheral write wrong");
    a_pbus_zero_wait: assert property (pri_rd && pri_size == SZ_WORD &&
        pri_pbus && !stall_r |=> pri_rvalid && core_rdata == {16'h0000, $past(pbus_rdata)})
        else $error("peripheral read late");
    a_sec_read_lat: assert property (sec_rd && !core_stall && !stall_r |=> sec_rvalid)
        else $error("secondary read not answered");
    a_stall_cause: assert property (core_stall |->
        sec_rd && sec_dfl && pri_dfl && (pri_rd || pri_wr)) else $error("stall without collision");
    a_collide_order: assert property (core_stall |=> pri_rvalid || !$past(pri_rd) ##1 sec_rvalid)
        else $error("collision order wrong");

    c_collision: cover property (core_stall ##1 !core_stall);
    c_byte_read: cover property (pri_rd && pri_size == SZ_BYTE);
    c_pbus_read: cover property (pri_rd && pri_pbus);
endmodule : fabric_monitor

bind core_memory_bus_fabric fabric_monitor mon (.clk(clk), .rst(rst), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_wr(prog_wr), .prog_rdata(prog_rdata), .prog_rvalid(prog_rvalid),
    .primary_data_address_bus(primary_data_address_bus), .pri_rd(pri_rd), .pri_wr(pri_wr),
    .pri_size(pri_size), .core_wdata(core_wdata), .core_rdata(core_rdata), .pri_rvalid(pri_rvalid),
    .secondary_data_address_bus(secondary_data_address_bus), .sec_rd(sec_rd),
    .sec_rvalid(sec_rvalid), .core_stall(core_stall), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_we(pmem_we), .pmem_wdata(pmem_wdata), .pmem_rdata(pmem_rdata), .dram_addr(dram_addr),
    .dram_rd(dram_rd), .dram_we(dram_we), .dram_be(dram_be), .dram_wdata(dram_wdata),
    .pbus_addr(pbus_addr), .pbus_we(pbus_we), .pbus_wdata(pbus_wdata), .pbus_rdata(pbus_rdata));

`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) check(nm, (got) === (ex), $sformatf("%h", ex), $sformatf("%h", got))

// ==========================================================
// Self-checking bench of the bus fabric
// ==========================================================
module tb;
    import fabric_pkg::*;
    typedef struct packed {
        logic [2:0] op; // 0 prog wr, 1 prog rd, 2 pri wr, 3 pri rd, 4 sec rd
        logic [23:0] addr;
        size_t size;
        logic [31:0] wdata;
        logic [31:0] exp;
    } row_t;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic prog_rd = 1'b0, prog_wr = 1'b0, pri_rd = 1'b0, pri_wr = 1'b0, sec_rd = 1'b0;
    logic [20:0] prog_addr = 21'h000000, pmem_addr;
    logic [23:0] primary_data_address_bus = 24'h000000;
    logic [23:0] secondary_data_address_bus = 24'h000000;
    size_t pri_size = SZ_WORD;
    logic [31:0] core_wdata = 32'h00000000, core_rdata, dram_wdata, dram_rdata;
    logic [15:0] prog_rdata, secondary_read_bus, pmem_wdata, pmem_rdata, dfl_wdata, dfl_rdata;
    logic [15:0] pbus_wdata, pbus_rdata, dram2_rdata;
    logic prog_rvalid, pri_rvalid, sec_rvalid, core_stall, pmem_rd, pmem_we, dram_rd, dram_we;
    logic dram2_rd, dfl_rd, dfl_we, pbus_rd, pbus_we;
    logic [10:0] dram_addr;
    logic [11:0] dram2_addr, dfl_addr, pbus_addr;
    logic [3:0] dram_be;
    logic [1:0] dfl_be, pbus_be;
    // Ordinary cases: each read follows the write that fills it, except two reads that expect zero
    row_t rows [16] = '{
        '{3'h0, 24'h0abcde, SZ_WORD, 32'hdead1234, 32'h0},
        '{3'h1, 24'h0abcde, SZ_WORD, 32'h0, 32'h1234},
        '{3'h2, 24'h000010, SZ_LONG, 32'h89abcdef, 32'h0},
        '{3'h3, 24'h000010, SZ_LONG, 32'h0, 32'h89abcdef},
        '{3'h3, 24'h000011, SZ_WORD, 32'h0, 32'h89ab},
        '{3'h3, 24'h800021, SZ_BYTE, 32'h0, 32'hcd},
        '{3'h4, 24'h000011, SZ_WORD, 32'h0, 32'h89ab},
        '{3'h2, 24'h00f005, SZ_WORD, 32'hffff5a5a, 32'h0},
        '{3'h3, 24'h00f005, SZ_WORD, 32'h0, 32'h5a5a},
        '{3'h2, 24'h004003, SZ_WORD, 32'h0000c3c3, 32'h0},
        '{3'h2, 24'h004006, SZ_LONG, 32'h11112222, 32'h0},
        '{3'h3, 24'h004006, SZ_LONG, 32'h0, 32'h2222},
        '{3'h3, 24'h002000, SZ_WORD, 32'h0, 32'h0},
        '{3'h4, 24'h00f005, SZ_WORD, 32'h0, 32'h0},
        '{3'h2, 24'h800043, SZ_BYTE, 32'h000000a5, 32'h0},
        '{3'h3, 24'h000021, SZ_WORD, 32'h0, 32'ha500}};

    core_memory_bus_fabric uut (.*);
    fabric_mem_model mem (.*);

    always #10 clk = ~clk;

    // Hang guard: the whole run needs about 55 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic check(input string nm, input bit ok, input string e, input string g);
        n_compared++;
        if (!ok) begin
            n_mismatch++;
            $display("Error %s expected %s seen %s", nm, e, g);
        end
    endtask : check

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // One request held for one taking edge, answer read after it
    task automatic run_row(input row_t r);
        @(posedge clk);
        prog_addr <= r.addr[20:0];
        primary_data_address_bus <= r.addr;
        secondary_data_address_bus <= r.addr;
        pri_size <= r.size;
        core_wdata <= r.wdata;
        {prog_wr, prog_rd, pri_wr, pri_rd, sec_rd} <= 5'b10000 >> r.op;
        @(posedge clk);
        {prog_wr, prog_rd, pri_wr, pri_rd, sec_rd} <= 5'b00000;
        #1;
        if (r.op == 3'h1)
            `CHK("prog_rdata", {1'b1, r.exp[15:0]}, {prog_rvalid, prog_rdata});
        if (r.op == 3'h3) `CHK("core_rdata", {1'b1, r.exp}, {pri_rvalid, core_rdata});
        if (r.op == 3'h4)
            `CHK("sec_bus", {1'b1, r.exp[15:0]}, {sec_rvalid, secondary_read_bus});
    endtask : run_row

    // Primary and secondary reads issued in the same cycle
    task automatic dual(input logic [23:0] pa, input size_t sz, input logic [23:0] sa,
                        input logic stall, input logic [31:0] ep, input logic [15:0] es);
        @(posedge clk);
        primary_data_address_bus <= pa;
        pri_size <= sz;
        secondary_data_address_bus <= sa;
        {pri_rd, sec_rd} <= 2'b11;
        #1;
        `CHK("core_stall", stall, core_stall);
        if (stall) begin
            @(posedge clk);
            #1;
            `CHK("core_rdata", {1'b1, ep}, {pri_rvalid, core_rdata});
        end
        @(posedge clk);
        {pri_rd, sec_rd} <= 2'b00;
        #1;
        `CHK("pri_rvalid", ~stall, pri_rvalid);
        `CHK("sec_bus", {1'b1, es}, {sec_rvalid, secondary_read_bus});
        if (!stall) `CHK("core_rdata", ep, core_rdata);
    endtask : dual

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("valids", 3'b000, {prog_rvalid, pri_rvalid, sec_rvalid});
        `CHK("core_rdata", 32'h00000000, core_rdata);
        $display("Test reset done");
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        $display("Test rows done");
        dual(24'h000010, SZ_LONG, 24'h000011, 1'b0, 32'h89abcdef, 16'h89ab);
        $display("Test dual ram read done");
        dual(24'h004003, SZ_WORD, 24'h004006, 1'b1, 32'h0000c3c3, 16'h2222);
        $display("Test flash collision done");
        run_row(rows[3]);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK("core_rdata", 32'h00000000, core_rdata);
        run_row(rows[8]);
        $display("Test mid reset done");
        stop_test();
    end
endmodule : tb

`default_nettype wire

// ===== design/core_memory_bus_fabric.sv
`timescale 1ns/100ps
`default_nettype none

module core_memory_bus_fabric
    import fabric_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // Program memory interface from the core
    input wire logic [fabric_pkg::PROG_AW-1:0] prog_addr,
    input wire logic prog_rd,
    input wire logic prog_wr,
    output logic [fabric_pkg::WORD_W-1:0] prog_rdata,
    output logic prog_rvalid,
    // Primary data interface from the core
    input wire logic [fabric_pkg::DATA_AW-1:0] primary_data_address_bus,
    input wire logic pri_rd,
    input wire logic pri_wr,
    input wire fabric_pkg::size_t pri_size,
    input wire logic [fabric_pkg::LONG_W-1:0] core_wdata,
    output logic [fabric_pkg::LONG_W-1:0] core_rdata,
    output logic pri_rvalid,
    // Secondary data interface from the core (word reads only)
    input wire logic [fabric_pkg::DATA_AW-1:0] secondary_data_address_bus,
    input wire logic sec_rd,
    output logic [fabric_pkg::WORD_W-1:0] secondary_read_bus,
    output logic sec_rvalid,
    // Core hold request while a collision is resolved
    output logic core_stall,
    // Program memory port (program RAM and program flash array)
    output logic [fabric_pkg::PROG_AW-1:0] pmem_addr,
    output logic pmem_rd,
    output logic pmem_we,
    output logic [fabric_pkg::WORD_W-1:0] pmem_wdata,
    input wire logic [fabric_pkg::WORD_W-1:0] pmem_rdata,
    // Primary data RAM port, 32 bits wide
    output logic [fabric_pkg::DRAM_IW-1:0] dram_addr,
    output logic dram_rd,
    output logic dram_we,
    output logic [3:0] dram_be,
    output logic [fabric_pkg::LONG_W-1:0] dram_wdata,
    input wire logic [fabric_pkg::LONG_W-1:0] dram_rdata,
    // Secondary data RAM read port, 16 bits wide
    output logic [fabric_pkg::DRAM_WW-1:0] dram2_addr,
    output logic dram2_rd,
    input wire logic [fabric_pkg::WORD_W-1:0] dram2_rdata,
    // Data flash array port, 16 bits wide, single ported
    output logic [fabric_pkg::DFL_AW-1:0] dfl_addr,
    output logic dfl_rd,
    output logic dfl_we,
    output logic [1:0] dfl_be,
    output logic [fabric_pkg::WORD_W-1:0] dfl_wdata,
    input wire logic [fabric_pkg::WORD_W-1:0] dfl_rdata,
    // Peripheral register bus, 16 bits wide
    output logic [fabric_pkg::PBUS_AW-1:0] pbus_addr,
    output logic pbus_rd,
    output logic pbus_we,
    output logic [1:0] pbus_be,
    output logic [fabric_pkg::WORD_W-1:0] pbus_wdata,
    input wire logic [fabric_pkg::WORD_W-1:0] pbus_rdata
);
    import fabric_pkg::*;

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Address decoder shared by the primary and secondary paths
    function automatic target_t decode(input logic [23:0] a);
        target_t t;
        t = TGT_NONE;
        if (a >= DRAM_BASE && a <= DRAM_LAST) begin
            t = TGT_DRAM;
        end else if (a >= DFL_BASE && a <= DFL_LAST) begin
            t = TGT_DFL;
        end else if (a >= PBUS_BASE && a <= PBUS_LAST) begin
            t = TGT_PBUS;
        end
        return t;
    endfunction : decode

    // Zero-extended read of one 16-bit word, narrowed to a byte if asked
    function automatic logic [31:0] rd16(input logic [15:0] d, input size_t sz,
                                         input logic lane);
        logic [31:0] r;
        r = {WORD_ZERO, d};
        if (sz == SZ_BYTE) begin
            r = {WORD_ZERO, 8'h00, (lane ? d[15:8] : d[7:0])};
        end
        return r;
    endfunction : rd16

    // Byte enables for a 16-bit port; long cycles reach the low word only
    function automatic logic [1:0] be16(input size_t sz, input logic lane);
        logic [1:0] b;
        b = BE_WORD;
        if (sz == SZ_BYTE) begin
            b = lane ? BE_HI_BYTE : BE_LO_BYTE;
        end
        return b;
    endfunction : be16

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        fab_state_t st;             // Flash port arbitration state
        logic [15:0] prog_rdata;    // Program read word
        logic prog_rvalid;          // Program read word valid
        logic [31:0] pri_rdata;     // Primary read data
        logic pri_rvalid;           // Primary read data valid
        logic [15:0] sec_rdata;     // Secondary read word
        logic sec_rvalid;           // Secondary read word valid
    } fab_t;

    fab_t state_r;                  // Registered state
    fab_t state_nxt;                // Next state

    // ==========================================================
    // Routing and arbitration
    // ==========================================================
    always_comb begin
        logic [23:0] pri_eff;
        logic [23:0] pri_word;
        logic [23:0] pri_off;
        logic [23:0] sec_off;
        logic lane;
        target_t pri_tgt;
        target_t sec_tgt;
        logic pri_go;
        logic sec_go;
        logic collide;
        logic [15:0] w16;
        pri_eff = primary_data_address_bus;
        pri_word = primary_data_address_bus;
        pri_off = 24'h000000;
        sec_off = 24'h000000;
        lane = 1'b0;
        pri_tgt = TGT_NONE;
        sec_tgt = TGT_NONE;
        pri_go = 1'b0;
        sec_go = 1'b0;
        collide = 1'b0;
        w16 = core_wdata[15:0];
        state_nxt = state_r;
        state_nxt.prog_rvalid = 1'b0;
        state_nxt.pri_rvalid = 1'b0;
        state_nxt.sec_rvalid = 1'b0;
        // Byte cycles carry a byte address; the word index drops the lane bit
        // byte MSB forced
        if (pri_size == SZ_BYTE) begin
            pri_eff = {1'b0, primary_data_address_bus[22:0]};
            pri_word = {1'b0, pri_eff[23:1]};
            lane = pri_eff[0];
        end
        pri_tgt = decode(pri_word);
        sec_tgt = decode(secondary_data_address_bus);
        // Second cycle of a collision starts no primary cycle and finishes the secondary read
        pri_go = (pri_rd || pri_wr) && (state_r.st == ST_IDLE);
        sec_go = sec_rd;
        collide = pri_go && (pri_tgt == TGT_DFL) && sec_go && (sec_tgt == TGT_DFL);
        core_stall = collide;
        // Arbitration: one extra cycle, then back to idle
        case (state_r.st)
            ST_IDLE: begin
                if (collide) begin
                    state_nxt.st = ST_SEC_PEND;
                end
            end
            ST_SEC_PEND: begin
                state_nxt.st = ST_IDLE;
            end
            default: begin
                state_nxt.st = ST_IDLE;
            end
        endcase

        // Program path; a held write is not repeated during the extra cycle
        // program address through
        pmem_addr = prog_addr;
        pmem_rd = prog_rd;
        pmem_we = prog_wr && (state_r.st == ST_IDLE);
        pmem_wdata = core_wdata[15:0];
        if (prog_rd) begin
            state_nxt.prog_rdata = pmem_rdata;
            state_nxt.prog_rvalid = 1'b1;
        end

        // Primary data RAM port, long-indexed with four byte lanes
        pri_off = pri_word - DRAM_BASE;
        dram_addr = pri_off[DRAM_IW:1];
        dram_rd = pri_go && pri_rd && (pri_tgt == TGT_DRAM);
        dram_we = pri_go && pri_wr && (pri_tgt == TGT_DRAM);
        dram_be = BE_LONG;
        dram_wdata = core_wdata;
        if (pri_size == SZ_WORD) begin
            dram_be = pri_off[0] ? BE_HI_WORD : BE_LO_WORD;
            dram_wdata = {w16, w16};
        end else if (pri_size == SZ_BYTE) begin
            dram_be = pri_off[0] ? {be16(pri_size, lane), 2'b00}
                                 : {2'b00, be16(pri_size, lane)};
            dram_wdata = {4{core_wdata[7:0]}};
        end

        // Shared flash port: held secondary first, then primary, then secondary
        // flash array direct
        dfl_addr = pri_off[DFL_AW-1:0];
        dfl_rd = 1'b0;
        dfl_we = 1'b0;
        dfl_be = be16(pri_size, lane);
        dfl_wdata = (pri_size == SZ_BYTE) ? {2{core_wdata[7:0]}} : w16;
        sec_off = secondary_data_address_bus - DFL_BASE;
        pri_off = pri_word - DFL_BASE;
        if (state_r.st == ST_SEC_PEND) begin
            dfl_addr = sec_off[DFL_AW-1:0];
            dfl_rd = sec_go && (sec_tgt == TGT_DFL);
            dfl_be = BE_WORD;
        end else if (pri_go && (pri_tgt == TGT_DFL)) begin
            dfl_addr = pri_off[DFL_AW-1:0];
            dfl_rd = pri_rd;
            dfl_we = pri_wr;
        end else if (sec_go && (sec_tgt == TGT_DFL)) begin
            dfl_addr = sec_off[DFL_AW-1:0];
            dfl_rd = 1'b1;
            dfl_be = BE_WORD;
        end

        // Peripheral register bus; flash control registers live here too
        pri_off = pri_word - PBUS_BASE;
        pbus_addr = pri_off[PBUS_AW-1:0];
        pbus_rd = pri_go && pri_rd && (pri_tgt == TGT_PBUS);
        pbus_we = pri_go && pri_wr && (pri_tgt == TGT_PBUS);
        pbus_be = be16(pri_size, lane);
        pbus_wdata = (pri_size == SZ_BYTE) ? {2{core_wdata[7:0]}} : w16;

        // Secondary data RAM read port, word indexed
        // concurrent secondary access
        sec_off = secondary_data_address_bus - DRAM_BASE;
        dram2_addr = sec_off[DRAM_WW-1:0];
        dram2_rd = sec_go && (sec_tgt == TGT_DRAM) && (state_r.st == ST_IDLE);

        // Primary read data capture; unmapped reads return zero
        // primary read return
        if (pri_go && pri_rd) begin
            state_nxt.pri_rvalid = 1'b1;
            pri_off = pri_word - DRAM_BASE;
            case (pri_tgt)
                TGT_DRAM: begin
                    if (pri_size == SZ_LONG) begin
                        state_nxt.pri_rdata = dram_rdata;
                    end else begin
                        state_nxt.pri_rdata = rd16(pri_off[0] ? dram_rdata[31:16]
                                                              : dram_rdata[15:0],
                                                   pri_size, lane);
                    end
                end
                TGT_DFL: begin
                    state_nxt.pri_rdata = rd16(dfl_rdata, pri_size, lane);
                end
                TGT_PBUS: begin
                    state_nxt.pri_rdata = rd16(pbus_rdata, pri_size, lane);
                end
                default: begin
                    state_nxt.pri_rdata = LONG_ZERO;
                end
            endcase
        end

        // Secondary read capture; deferred while the flash port serves primary
        // secondary word return
        if (sec_go && !collide) begin
            state_nxt.sec_rvalid = 1'b1;
            case (sec_tgt)
                TGT_DRAM: begin
                    state_nxt.sec_rdata = (state_r.st == ST_IDLE) ? dram2_rdata
                                                                  : state_r.sec_rdata;
                end
                TGT_DFL: begin
                    state_nxt.sec_rdata = dfl_rdata;
                end
                default: begin
                    state_nxt.sec_rdata = WORD_ZERO;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Read data and valid outputs come straight from the state flops
    assign prog_rdata = state_r.prog_rdata;
    assign prog_rvalid = state_r.prog_rvalid;
    assign core_rdata = state_r.pri_rdata;
    assign pri_rvalid = state_r.pri_rvalid;
    assign secondary_read_bus = state_r.sec_rdata;
    assign sec_rvalid = state_r.sec_rvalid;

endmodule : core_memory_bus_fabric

`default_nettype wire

// ===== design/fabric_pkg.sv
package fabric_pkg;

    // ==========================================================
    // Bus widths
    // ==========================================================
    localparam int PROG_AW = 21;          // Program address bus width
    localparam int DATA_AW = 24;          // Primary and secondary data address width
    localparam int WORD_W = 16;           // Program, secondary and peripheral word width
    localparam int LONG_W = 32;           // Primary core read and write bus width
    localparam int DRAM_IW = 11;          // Long index width of the primary data RAM port
    localparam int DRAM_WW = 12;          // Word index width of the secondary data RAM port
    localparam int DFL_AW = 12;           // Word index width of the data flash port
    localparam int PBUS_AW = 12;          // Word index width of the peripheral register bus

    // ==========================================================
    // Data address map (word addresses)
    // ==========================================================
    localparam logic [23:0] DRAM_BASE = 24'h000000;
    localparam logic [23:0] DRAM_LAST = 24'h000fff;
    localparam logic [23:0] DFL_BASE = 24'h004000;
    localparam logic [23:0] DFL_LAST = 24'h004fff;
    localparam logic [23:0] PBUS_BASE = 24'h00f000;
    localparam logic [23:0] PBUS_LAST = 24'h00ffff;

    // ==========================================================
    // Byte enables and zero fill values
    // ==========================================================
    localparam logic [3:0] BE_LONG = 4'hf;
    localparam logic [3:0] BE_HI_WORD = 4'hc;
    localparam logic [3:0] BE_LO_WORD = 4'h3;
    localparam logic [1:0] BE_WORD = 2'h3;
    localparam logic [1:0] BE_HI_BYTE = 2'h2;
    localparam logic [1:0] BE_LO_BYTE = 2'h1;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [31:0] LONG_ZERO = 32'h00000000;

    // Access size presented with each primary cycle
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } size_t;

    // Target chosen by the data address decoder
    typedef enum logic [1:0] {
        TGT_NONE = 2'b00,
        TGT_DRAM = 2'b01,
        TGT_DFL = 2'b10,
        TGT_PBUS = 2'b11
    } target_t;

    // Arbitration state of the shared flash port
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEC_PEND = 1'b1
    } fab_state_t;

endpackage : fabric_pkg
